// [tmcr_config_bank.sv]
// configuration, status, mask and trip point registers of the monitor
`timescale 1ns/1ps
`default_nettype none

// Contract
// - config bit 0 runs the device, zero means standby; resets one.
// - clearing run never deasserts the interrupt output by itself.
// - with run set, monitoring and limit comparison are enabled.
// - config bit 1 enables the interrupt output; resets zero.
// - config bit 2 holds interrupt output off, status kept; resets one.
// - setting bit 3 freezes both programmable trip point registers.
// - with lock set, fixed default trip points no longer steer outputs.
// - lock ignores writes until secondary reset or power-on; resets zero.
// - a one in bit 4 restores config (except lock), status, mirror and mask defaults.
// - soft reset bit returns to zero by itself.
// - bit 5 one floats fan-off pin, zero drives it low; resets one.
// - an asserted thermal overload pin forces bit 5 to one.
// - reading bit 5 returns the output buffer state, not the pin level.
// - bit 6 inverts the general input before detection; resets zero.
// - bit 7 gives shared pins to second diode; else thermal out, input.
// - interrupt status holds all zeros after power-on.
// - trip point writes take effect only while the lock is clear.
// - general input status bit is live, unlatched, not cleared by reads.
module tmcr_config_bank #(
  parameter int DATA_W = 8
) (
  input wire logic clk, // 25 MHz device clock
  input wire logic rst, // synchronous power-on reset, high
  input wire logic [7:0] reg_addr, // register address
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_rd, // read strobe, one cycle
  input wire logic [DATA_W-1:0] reg_wdata, // write data
  output logic [DATA_W-1:0] reg_rdata, // read data, registered
  input wire logic [DATA_W-1:0] status_event, // limit and fault events
  input wire logic thermal_overload_pin_drive_req, // converter asks for thermal out
  input wire logic thermal_overload_pin_i, // thermal overload pin level
  output logic thermal_overload_pin_o, // thermal overload pin drive value
  output logic thermal_overload_pin_oe, // thermal overload pin drive enable
  input wire logic gpi_i, // general purpose input pin
  input wire logic secondary_reset_input_n_i, // secondary reset input pin, low
  output logic fan_off_o, // fan-off pin drive value
  output logic fan_off_oe, // fan-off pin drive enable
  output logic int_n, // interrupt output, low active
  output logic monitor_run, // monitoring and comparison enable
  output logic trip_lock, // trip points locked
  output logic default_trip_active, // fixed defaults still steer outputs
  output logic [DATA_W-1:0] trip_local, // programmable local trip point
  output logic [DATA_W-1:0] trip_remote, // programmable remote trip point
  output logic second_diode_mode // shared pins serve second diode
);

  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [DATA_W-1:0] cfg_ff;
  logic [DATA_W-1:0] nxt_cfg;
  logic [DATA_W-1:0] status_ff;
  logic [DATA_W-1:0] nxt_status;
  logic [DATA_W-1:0] mirror_ff;
  logic [DATA_W-1:0] nxt_mirror;
  logic [DATA_W-1:0] mask_ff;
  logic [DATA_W-1:0] nxt_mask;
  logic [DATA_W-1:0] trip_local_ff;
  logic [DATA_W-1:0] nxt_trip_local;
  logic [DATA_W-1:0] trip_remote_ff;
  logic [DATA_W-1:0] nxt_trip_remote;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic int_ff;
  logic nxt_int;
  logic thermal_overload_pin_asserted;
  logic gpi_level;
  logic secondary_reset_input_active;
  logic soft_reset;
  logic [DATA_W-1:0] sticky_set;
  logic [DATA_W-1:0] live_bits;
  logic [DATA_W-1:0] status_view;
  logic [DATA_W-1:0] mirror_view;
  logic wr_cfg;
  logic rd_status;
  logic rd_mirror;
  logic wr_mask;
  logic wr_trip_ok;
  logic wr_trip_local;
  logic wr_trip_remote;
  logic [DATA_W-1:0] int_src;

  // pins pass two flops before any logic sees them
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_ff <= tmcr_pkg::SYNC_RESET;
      sync2_ff <= tmcr_pkg::SYNC_RESET;
    end else begin
      sync1_ff <= {secondary_reset_input_n_i, gpi_i, thermal_overload_pin_i};
      sync2_ff <= sync1_ff;
    end
  end

  assign secondary_reset_input_active = ~sync2_ff[tmcr_pkg::SYNC_SECONDARY_RESET_INPUT];
  // shared pins only mean thermal/general input in single-diode mode
  assign thermal_overload_pin_asserted = ~sync2_ff[tmcr_pkg::SYNC_THERMAL_OVERLOAD_PIN] &
    ~cfg_ff[tmcr_pkg::CFG_SECOND_DIODE_SELECT];
  assign gpi_level = (sync2_ff[tmcr_pkg::SYNC_GPI] ^
    cfg_ff[tmcr_pkg::CFG_GENERAL_INPUT_INVERT]) &
    ~cfg_ff[tmcr_pkg::CFG_SECOND_DIODE_SELECT];

  assign wr_cfg = reg_wr & (reg_addr == tmcr_pkg::ADDR_DEVICE_CONFIGURATION);
  // the reset bit is never stored, so it reads back zero at once
  assign soft_reset = wr_cfg & reg_wdata[tmcr_pkg::CFG_SOFT_RESET];
  assign rd_status = reg_rd & (reg_addr == tmcr_pkg::ADDR_INTERRUPT_STATUS);
  assign rd_mirror = reg_rd & (reg_addr == tmcr_pkg::ADDR_INTERRUPT_MIRROR);
  assign wr_mask = reg_wr & (reg_addr == tmcr_pkg::ADDR_INTERRUPT_MASK);

  // a set lock freezes both programmable trip points
  assign wr_trip_ok = reg_wr &
    ~cfg_ff[tmcr_pkg::CFG_TRIP_POINT_LOCK];
  assign wr_trip_local = wr_trip_ok &
    (reg_addr == tmcr_pkg::ADDR_TRIP_LOCAL_PROG);
  assign wr_trip_remote = wr_trip_ok &
    (reg_addr == tmcr_pkg::ADDR_TRIP_REMOTE_PROG);

  // limit events only count while the device runs
  always_comb begin
    sticky_set = '0;
    if (cfg_ff[tmcr_pkg::CFG_RUN]) begin
      sticky_set = status_event;
    end
    sticky_set[tmcr_pkg::STS_GENERAL_INPUT] = 1'b0;
    sticky_set[tmcr_pkg::STS_RESERVED] = 1'b0;
    sticky_set[tmcr_pkg::STS_THERMAL_INPUT] = thermal_overload_pin_asserted;
  end

  always_comb begin
    live_bits = '0;
    live_bits[tmcr_pkg::STS_GENERAL_INPUT] = gpi_level;
  end

  assign status_view = status_ff | live_bits;
  assign mirror_view = mirror_ff | live_bits;
  // live gpi level is an interrupt source too, not only a status bit
  assign int_src = (sticky_set | live_bits) & ~mask_ff;

  // configuration register
  always_comb begin
    nxt_cfg = cfg_ff;
    if (soft_reset) begin
      nxt_cfg = tmcr_pkg::CFG_RESET;
      // lock survives soft reset, only secondary or power-on reset frees it
      nxt_cfg[tmcr_pkg::CFG_TRIP_POINT_LOCK] =
        cfg_ff[tmcr_pkg::CFG_TRIP_POINT_LOCK];
    end else if (wr_cfg) begin
      nxt_cfg = reg_wdata;
      nxt_cfg[tmcr_pkg::CFG_SOFT_RESET] = 1'b0;
      // write once: a set lock ignores further writes
      nxt_cfg[tmcr_pkg::CFG_TRIP_POINT_LOCK] =
        cfg_ff[tmcr_pkg::CFG_TRIP_POINT_LOCK] |
        reg_wdata[tmcr_pkg::CFG_TRIP_POINT_LOCK];
    end
    if (secondary_reset_input_active) begin
      nxt_cfg[tmcr_pkg::CFG_TRIP_POINT_LOCK] = 1'b0;
    end
    // overload wins over any software setting of the fan bit
    if (thermal_overload_pin_asserted) begin
      nxt_cfg[tmcr_pkg::CFG_FAN_STOP_RELEASE] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_ff <= tmcr_pkg::CFG_RESET;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // status and mirror: sticky, cleared on their own read, set wins
  always_comb begin
    nxt_status = status_ff;
    nxt_mirror = mirror_ff;
    if (soft_reset) begin
      nxt_status = tmcr_pkg::STATUS_RESET;
      nxt_mirror = tmcr_pkg::STATUS_RESET;
    end else begin
      // each register clears on its own read only
      if (rd_status) begin
        nxt_status = '0;
      end
      if (rd_mirror) begin
        nxt_mirror = '0;
      end
    end
    nxt_status = nxt_status | sticky_set;
    nxt_mirror = nxt_mirror | sticky_set;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_ff <= tmcr_pkg::STATUS_RESET;
      mirror_ff <= tmcr_pkg::STATUS_RESET;
    end else begin
      status_ff <= nxt_status;
      mirror_ff <= nxt_mirror;
    end
  end

  // mask and trip point registers
  always_comb begin
    nxt_mask = mask_ff;
    nxt_trip_local = trip_local_ff;
    nxt_trip_remote = trip_remote_ff;
    if (soft_reset) begin
      nxt_mask = tmcr_pkg::MASK_RESET;
    end else if (wr_mask) begin
      nxt_mask = reg_wdata;
      nxt_mask[tmcr_pkg::STS_RESERVED] = 1'b0;
    end
    if (wr_trip_local) begin
      nxt_trip_local = reg_wdata;
    end
    if (wr_trip_remote) begin
      nxt_trip_remote = reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_ff <= tmcr_pkg::MASK_RESET;
      trip_local_ff <= tmcr_pkg::TRIP_LOCAL_RESET;
      trip_remote_ff <= tmcr_pkg::TRIP_REMOTE_RESET;
    end else begin
      mask_ff <= nxt_mask;
      trip_local_ff <= nxt_trip_local;
      trip_remote_ff <= nxt_trip_remote;
    end
  end

  // interrupt latch: the clear bit is a level that holds it off;
  // run is deliberately absent so standby cannot drop a pending alert
  always_comb begin
    nxt_int = int_ff;
    if (cfg_ff[tmcr_pkg::CFG_ALERT_OUTPUT_ENABLE] &&
        |int_src) begin
      nxt_int = 1'b1;
    end
    if (cfg_ff[tmcr_pkg::CFG_ALERT_OUTPUT_CLEAR]) begin
      nxt_int = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      int_ff <= 1'b0;
    end else begin
      int_ff <= nxt_int;
    end
  end

  // read data, registered one cycle after the strobe
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      case (reg_addr)
        tmcr_pkg::ADDR_DEVICE_CONFIGURATION: nxt_rdata = cfg_ff;
        tmcr_pkg::ADDR_INTERRUPT_STATUS: nxt_rdata = status_view;
        tmcr_pkg::ADDR_INTERRUPT_MASK: nxt_rdata = mask_ff;
        tmcr_pkg::ADDR_INTERRUPT_MIRROR: nxt_rdata = mirror_view;
        tmcr_pkg::ADDR_TRIP_LOCAL_PROG: nxt_rdata = trip_local_ff;
        tmcr_pkg::ADDR_TRIP_REMOTE_PROG: nxt_rdata = trip_remote_ff;
        tmcr_pkg::ADDR_TRIP_LOCAL_DEF: nxt_rdata = tmcr_pkg::TRIP_LOCAL_RESET;
        tmcr_pkg::ADDR_TRIP_REMOTE_DEF:
          nxt_rdata = tmcr_pkg::TRIP_REMOTE_RESET;
        default: nxt_rdata = tmcr_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= tmcr_pkg::RDATA_RESET;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign int_n = ~int_ff;
  assign monitor_run = cfg_ff[tmcr_pkg::CFG_RUN];
  assign trip_lock = cfg_ff[tmcr_pkg::CFG_TRIP_POINT_LOCK];
  assign default_trip_active =
    ~cfg_ff[tmcr_pkg::CFG_TRIP_POINT_LOCK];
  assign trip_local = trip_local_ff;
  assign trip_remote = trip_remote_ff;
  assign second_diode_mode = cfg_ff[tmcr_pkg::CFG_SECOND_DIODE_SELECT];
  // open drain: only ever pulls low
  assign fan_off_o = 1'b0;
  assign fan_off_oe = ~cfg_ff[tmcr_pkg::CFG_FAN_STOP_RELEASE];
  assign thermal_overload_pin_o = 1'b0;
  assign thermal_overload_pin_oe = thermal_overload_pin_drive_req &
    ~cfg_ff[tmcr_pkg::CFG_SECOND_DIODE_SELECT];

endmodule

`default_nettype wire

// [tmcr_pkg.sv]
// constants for the thermal monitor configuration register bank
package tmcr_pkg;
  // register addresses
  localparam logic [7:0] ADDR_TRIP_LOCAL_PROG = 8'h13;
  localparam logic [7:0] ADDR_TRIP_REMOTE_PROG = 8'h14;
  localparam logic [7:0] ADDR_TRIP_LOCAL_DEF = 8'h17;
  localparam logic [7:0] ADDR_TRIP_REMOTE_DEF = 8'h18;
  localparam logic [7:0] ADDR_DEVICE_CONFIGURATION = 8'h40;
  localparam logic [7:0] ADDR_INTERRUPT_STATUS = 8'h41;
  localparam logic [7:0] ADDR_INTERRUPT_MASK = 8'h43;
  localparam logic [7:0] ADDR_INTERRUPT_MIRROR = 8'h4C;

  // device_configuration field positions
  localparam int CFG_RUN = 0;
  localparam int CFG_ALERT_OUTPUT_ENABLE = 1;
  localparam int CFG_ALERT_OUTPUT_CLEAR = 2;
  localparam int CFG_TRIP_POINT_LOCK = 3;
  localparam int CFG_SOFT_RESET = 4;
  localparam int CFG_FAN_STOP_RELEASE = 5;
  localparam int CFG_GENERAL_INPUT_INVERT = 6;
  localparam int CFG_SECOND_DIODE_SELECT = 7;

  // interrupt_status field positions
  localparam int STS_GENERAL_INPUT = 4;
  localparam int STS_THERMAL_INPUT = 6;
  localparam int STS_RESERVED = 3;

  // values after reset
  localparam logic [7:0] CFG_RESET = 8'h25;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] TRIP_LOCAL_RESET = 8'h46;
  localparam logic [7:0] TRIP_REMOTE_RESET = 8'h64;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // pin synchroniser reset levels: thermal_overload_pin, general input, secondary reset
  localparam logic [2:0] SYNC_RESET = 3'h5;
  localparam int SYNC_THERMAL_OVERLOAD_PIN = 0;
  localparam int SYNC_GPI = 1;
  localparam int SYNC_SECONDARY_RESET_INPUT = 2;
endpackage

// [tmcr_config_bank_monitor.sv]
// port assertions for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tmcr_config_bank_monitor (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic [7:0] reg_addr, // address
  input wire logic reg_wr, // write
  input wire logic [7:0] reg_wdata, // wdata
  input wire logic secondary_reset_input_n_i, // reset pin
  input wire logic thermal_overload_pin_oe, // thermal_overload_pin enable
  input wire logic fan_off_o, // fan value
  input wire logic fan_off_oe, // fan enable
  input wire logic int_n, // interrupt
  input wire logic monitor_run, // run
  input wire logic trip_lock, // lock
  input wire logic default_trip_active, // defaults
  input wire logic second_diode_mode // diode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic wc;
  assign wc = reg_wr && reg_addr == tmcr_pkg::ADDR_DEVICE_CONFIGURATION;
  chk_lock_flags: assert property (trip_lock != default_trip_active)
    else $error("lock flags agree");
  chk_fan_drain: assert property (fan_off_o == 1'b0)
    else $error("fan pin driven high");
  chk_diode_pins: assert property (second_diode_mode |-> !thermal_overload_pin_oe)
    else $error("thermal_overload_pin driven in diode mode");
  chk_lock_holds: assert property (
    secondary_reset_input_n_i [*3] ##0 trip_lock |=> trip_lock)
    else $error("lock lost");
  chk_lock_sets: assert property (secondary_reset_input_n_i [*3] ##0
    (wc && reg_wdata[3] && !reg_wdata[4]) |=> trip_lock)
    else $error("no lock");
  chk_soft_defaults: assert property (wc && reg_wdata[4] |=>
    monitor_run && !fan_off_oe && !second_diode_mode)
    else $error("no defaults");
  chk_int_cleared: assert property (
    wc && reg_wdata[2] |-> ##2 int_n)
    else $error("int not cleared");
  chk_int_disabled: assert property (
    wc && !reg_wdata[1] ##1 int_n |=> int_n)
    else $error("int while disabled");
  chk_run_follows: assert property (wc && !reg_wdata[4] |=>
    monitor_run == $past(reg_wdata[0])) else $error("run wrong");
  cover property (wc && reg_wdata[4]);
  cover property ($fell(int_n));
  cover property ($fell(trip_lock));
endmodule
bind tmcr_config_bank tmcr_config_bank_monitor u_tmcr_config_bank_monitor (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .secondary_reset_input_n_i(secondary_reset_input_n_i), .thermal_overload_pin_oe(thermal_overload_pin_oe),
  .fan_off_o(fan_off_o), .fan_off_oe(fan_off_oe), .int_n(int_n),
  .monitor_run(monitor_run), .trip_lock(trip_lock),
  .default_trip_active(default_trip_active),
  .second_diode_mode(second_diode_mode));
`default_nettype wire

// [tmcr_host_model.sv]
// bus host model driving the register strobe port
`timescale 1ns/1ps
`default_nettype none
module tmcr_host_model (
  input wire logic clk, // clock
  output logic [7:0] reg_addr, // address
  output logic reg_wr, // write
  output logic reg_rd, // read
  output logic [7:0] reg_wdata // wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one-cycle strobe; idle lines show inverted values so stale data is seen
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// [tb_thermal_monitor_config_register.sv]
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb_thermal_monitor_config_register;
  logic clk = 0, rst = 1, rd_d = 0, reg_wr, reg_rd, thermal_overload_pin_drive_req = 0;
  logic thermal_overload_pin_i = 1, gpi_i = 0, secondary_reset_input_n_i = 1, thermal_overload_pin_o, thermal_overload_pin_oe, fan_off_o;
  logic fan_off_oe, int_n, monitor_run, trip_lock, default_trip_active;
  logic second_diode_mode;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, trip_local, trip_remote, r;
  logic [7:0] status_event = 8'h00;
  logic [7:0] q[$];
  int miscompares = 0, tests_run = 0, cycles = 0;
  always #20 clk = ~clk;
  tmcr_host_model u_tmcr_host_model (.clk(clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  tmcr_config_bank u_tmcr_config_bank (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .status_event(status_event),
    .thermal_overload_pin_drive_req(thermal_overload_pin_drive_req), .thermal_overload_pin_i(thermal_overload_pin_i), .thermal_overload_pin_o(thermal_overload_pin_o),
    .thermal_overload_pin_oe(thermal_overload_pin_oe), .gpi_i(gpi_i), .secondary_reset_input_n_i(secondary_reset_input_n_i),
    .fan_off_o(fan_off_o), .fan_off_oe(fan_off_oe), .int_n(int_n),
    .monitor_run(monitor_run), .trip_lock(trip_lock),
    .default_trip_active(default_trip_active), .trip_local(trip_local),
    .trip_remote(trip_remote), .second_diode_mode(second_diode_mode));
  task cmp(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task summarize();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    u_tmcr_host_model.xfer(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    u_tmcr_host_model.xfer(1'b0, a, 8'h00);
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // read data lands one cycle after the strobe; sampled mid-cycle
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) if (rd_d) cmp("rdata", q.pop_front(), reg_rdata);
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'h6249FCB9));
    tick(4);
    rst = 0;
    rd(8'h40, 8'h25);
    rd(8'h41, 8'h00);
    rd(8'h42, 8'h00);
    rd(8'h17, tmcr_pkg::TRIP_LOCAL_RESET);
    rd(8'h18, tmcr_pkg::TRIP_REMOTE_RESET);
    r = 8'($urandom);
    wr(8'h13, r);
    wr(8'h14, ~r);
    rd(8'h13, r);
    rd(8'h14, ~r);
    wr(8'h40, 8'h2D);
    cmp("trip_lock", 8'h01, {7'h0, trip_lock});
    cmp("default_trip", 8'h00, {7'h0, default_trip_active});
    wr(8'h13, ~r);
    wr(8'h14, r);
    rd(8'h13, r);
    rd(8'h14, ~r);
    cmp("trip_local", r, trip_local);
    cmp("trip_remote", ~r, trip_remote);
    wr(8'h40, 8'h25);
    rd(8'h40, 8'h2D);
    secondary_reset_input_n_i = 0;
    tick(3);
    secondary_reset_input_n_i = 1;
    tick(3);
    rd(8'h40, 8'h25);
    for (int i = 0; i < 4; i++) begin
      gpi_i = 1'($urandom);
      wr(8'h40, {1'b0, i[0], 6'h25});
      rd(8'h41, {3'h0, gpi_i ^ i[0], 4'h0});
      rd(8'h41, {3'h0, gpi_i ^ i[0], 4'h0});
    end
    gpi_i = 0;
    wr(8'h43, r);
    rd(8'h43, r & 8'hF7);
    wr(8'h40, 8'hD6);
    rd(8'h40, 8'h25);
    rd(8'h43, 8'h00);
    // mask and limits settle before interrupts are enabled
    wr(8'h43, 8'h00);
    wr(8'h40, 8'h03);
    cmp("fan_oe", 8'h01, {7'h0, fan_off_oe});
    status_event = 8'h01;
    tick(1);
    status_event = 8'h00;
    tick(1);
    cmp("int_n", 8'h00, {7'h0, int_n});
    wr(8'h40, 8'h02);
    tick(1);
    cmp("int_n", 8'h00, {7'h0, int_n});
    cmp("run", 8'h00, {7'h0, monitor_run});
    // an event in standby must not reach the status register
    status_event = 8'h02;
    tick(1);
    status_event = 8'h00;
    wr(8'h40, 8'h06);
    tick(1);
    cmp("int_n", 8'h01, {7'h0, int_n});
    rd(8'h41, 8'h01);
    wr(8'h40, 8'h01);
    thermal_overload_pin_i = 0;
    tick(3);
    cmp("fan_oe", 8'h00, {7'h0, fan_off_oe});
    rd(8'h40, 8'h21);
    rd(8'h41, 8'h40);
    rd(8'h4C, 8'h41);
    thermal_overload_pin_i = 1;
    thermal_overload_pin_drive_req = 1;
    tick(1);
    cmp("thermal_overload_pin_oe", 8'h01, {7'h0, thermal_overload_pin_oe});
    cmp("thermal_overload_pin_o", 8'h00, {7'h0, thermal_overload_pin_o});
    wr(8'h40, 8'hA5);
    cmp("thermal_overload_pin_oe", 8'h00, {7'h0, thermal_overload_pin_oe});
    tick(2);
    summarize();
  end
endmodule
`default_nettype wire
